// >>> core/vrtc_pkg.sv
// Package: offsets, reset values and field positions of the tuning register bank
package vrtc_pkg;
  // Register command codes
  localparam logic [7:0] VRTC_ADDR_LOAD_LINE  = 8'hD8;
  localparam logic [7:0] VRTC_ADDR_TRANSIENT  = 8'hD9;
  localparam logic [7:0] VRTC_ADDR_MAX_CURR   = 8'hDA;
  localparam logic [7:0] VRTC_ADDR_BOOT_VOLT  = 8'hDB;
  localparam logic [7:0] VRTC_ADDR_FREQ_SS    = 8'hDC;
  // Values after reset (non-volatile defaults)
  localparam logic [7:0] VRTC_RST_LOAD_LINE   = 8'h04;
  localparam logic [7:0] VRTC_RST_TRANSIENT   = 8'h77;
  localparam logic [7:0] VRTC_RST_MAX_CURR    = 8'h78;
  localparam logic [7:0] VRTC_RST_BOOT_VOLT   = 8'h97;
  localparam logic [7:0] VRTC_RST_FREQ_SS     = 8'h20;
  // Writable bits of the threshold and frequency registers
  localparam logic [7:0] VRTC_MASK_TRANSIENT  = 8'h77;
  localparam logic [7:0] VRTC_MASK_FREQ_SS    = 8'hF3;
  // Field positions
  localparam int VRTC_UNDER_LSB = 4;
  localparam int VRTC_OVER_LSB  = 0;
  localparam int VRTC_FSW_LSB   = 4;
  localparam int VRTC_RISE_LSB  = 0;
  // Threshold code that switches reduction off
  localparam logic [2:0] VRTC_THR_OFF = 3'h7;
  // Strap capture happens one cycle after reset release
  localparam int VRTC_STRAP_CYCLES = 1;
endpackage

// >>> core/vrtc_regs.sv
// Tuning register bank: load line, transient thresholds, current, boot voltage, frequency
// How it works
// - Load-line code decodes to percent; unlisted codes act as 100 percent.
// - Undershoot field bits 6:4 select 20 to 140 mV thresholds.
// - Undershoot code 111 disables undershoot reduction.
// - Overshoot field bits 2:0 select 30 to 140 mV thresholds.
// - Overshoot code 111 disables overshoot reduction.
// - A written threshold value beats the transient strap value.
// - Threshold register loads from strap when present, otherwise 77h.
// - Maximum current register is an 8-bit value in amperes.
// - A written maximum current beats the frequency/current strap value.
// - Maximum current loads from strap when present, otherwise 78h.
// - Boot voltage register holds an 8-bit code overriding the boot strap.
// - Boot code is read through the currently selected voltage table.
// - Boot voltage loads from strap when present, otherwise 97h.
// - Frequency register selects frequency and rise ratio, overriding the strap.
// - Frequency register loads from strap when present, otherwise 20h.
// - Bits 7:4 select the switching frequency, 0000 meaning 300 kHz.
// - Bits 1:0 scale soft-start rise slew by 1, 1/2, 1/4, 1/8.
`timescale 1ns/1ps
`default_nettype none
module vrtc_regs
(
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_reset_n,
  // Register port
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  output logic      [7:0] o_reg_rdata,
  output logic            o_reg_hit,
  // Strap pins, valid flags mark a fitted strap
  input  wire logic [7:0] i_transient_strap_pin,
  input  wire logic       i_transient_strap_valid,
  input  wire logic [7:0] i_freq_current_strap_pin,
  input  wire logic [7:0] i_freq_current_strap_freq,
  input  wire logic       i_freq_current_strap_valid,
  input  wire logic [7:0] i_boot_strap_pin,
  input  wire logic       i_boot_strap_valid,
  // Voltage table selection
  input  wire logic       i_vid_table_sel,
  // Decoded settings to the analog loop
  output logic      [7:0] o_load_line_pct,
  output logic      [2:0] o_undershoot_threshold,
  output logic            o_undershoot_enable,
  output logic      [7:0] o_undershoot_mv,
  output logic      [2:0] o_overshoot_threshold,
  output logic            o_overshoot_enable,
  output logic      [7:0] o_overshoot_mv,
  output logic      [7:0] o_max_current_value,
  output logic      [7:0] o_boot_voltage_field,
  output logic            o_boot_vid_table,
  output logic      [3:0] o_switching_frequency_code,
  output logic      [9:0] o_switching_frequency_khz,
  output logic      [1:0] o_soft_start_rise_ratio,
  output logic      [3:0] o_soft_start_divisor
);
  import vrtc_pkg::*;

  function automatic logic [7:0] ll_pct(input logic [7:0] c);
    logic [7:0] p;
    p = 8'd100;
    if (c[7:4] == 4'h0 && c[3:0] <= 4'h4)
      p = 8'(c[3:0] * 25);
    else if (c[3:0] == 4'h0)
    begin
      unique case (c[7:4])
        4'h1: p = 8'd80;
        4'h2: p = 8'd85;
        4'h3: p = 8'd90;
        4'h4: p = 8'd95;
        4'h5: p = 8'd105;
        4'h6: p = 8'd110;
        4'h7: p = 8'd115;
        4'h8: p = 8'd120;
        4'h9: p = 8'd125;
        4'hA: p = 8'd150;
        4'hB: p = 8'd175;
        default: p = 8'd100;
      endcase
    end
    return p;
  endfunction

  // threshold decode, first two entries differ per field
  function automatic logic [7:0] thr_mv(input logic [2:0] c, input logic [7:0] first);
    logic [7:0] m;
    m = 8'd0;
    unique case (c)
      3'h0: m = first;
      3'h1: m = first + 8'd10;
      3'h2: m = 8'd60;
      3'h3: m = 8'd80;
      3'h4: m = 8'd100;
      3'h5: m = 8'd120;
      3'h6: m = 8'd140;
      3'h7: m = 8'd0;
    endcase
    return m;
  endfunction

  function automatic logic [9:0] fsw_khz(input logic [3:0] c);
    logic [9:0] k;
    k = 10'd300;
    unique case (c)
      4'h0: k = 10'd300;
      4'h1: k = 10'd400;
      4'h2: k = 10'd500;
      4'h3: k = 10'd600;
      4'h4: k = 10'd700;
      4'h5: k = 10'd800;
      4'h6: k = 10'd900;
      4'h7: k = 10'd1000;
      4'h8: k = 10'd300;
      4'h9: k = 10'd450;
      4'hA: k = 10'd350;
      4'hB: k = 10'd650;
      4'hC: k = 10'd550;
      4'hD: k = 10'd850;
      4'hE: k = 10'd950;
      4'hF: k = 10'd1000;
    endcase
    return k;
  endfunction

  logic [7:0] load_line_r;
  logic [7:0] transient_r;
  logic [7:0] max_curr_r;
  logic [7:0] boot_volt_r;
  logic [7:0] freq_ss_r;
  logic       strap_done_r;

  wire logic wr_ll   = i_reg_wr && (i_reg_addr == VRTC_ADDR_LOAD_LINE);
  wire logic wr_tr   = i_reg_wr && (i_reg_addr == VRTC_ADDR_TRANSIENT);
  wire logic wr_mc   = i_reg_wr && (i_reg_addr == VRTC_ADDR_MAX_CURR);
  wire logic wr_bv   = i_reg_wr && (i_reg_addr == VRTC_ADDR_BOOT_VOLT);
  wire logic wr_fs   = i_reg_wr && (i_reg_addr == VRTC_ADDR_FREQ_SS);
  wire logic strap_ld = !strap_done_r;
  wire logic addr_hit = (i_reg_addr >= VRTC_ADDR_LOAD_LINE) && (i_reg_addr <= VRTC_ADDR_FREQ_SS);

  // strap first, later writes win, reserved bits masked
  wire logic [7:0] transient_nxt =
    (strap_ld && i_transient_strap_valid) ? (i_transient_strap_pin & VRTC_MASK_TRANSIENT) :
    wr_tr ? (i_reg_wdata & VRTC_MASK_TRANSIENT) : transient_r;
  wire logic [7:0] max_curr_nxt =
    (strap_ld && i_freq_current_strap_valid) ? i_freq_current_strap_pin :
    wr_mc ? i_reg_wdata : max_curr_r;
  wire logic [7:0] boot_volt_nxt =
    (strap_ld && i_boot_strap_valid) ? i_boot_strap_pin :
    wr_bv ? i_reg_wdata : boot_volt_r;
  // strap first, later writes win; bits 3:2 stay zero
  wire logic [7:0] freq_ss_nxt =
    (strap_ld && i_freq_current_strap_valid) ? (i_freq_current_strap_freq & VRTC_MASK_FREQ_SS) :
    wr_fs ? (i_reg_wdata & VRTC_MASK_FREQ_SS) : freq_ss_r;
  wire logic [7:0] load_line_nxt = wr_ll ? i_reg_wdata : load_line_r;

  wire logic [7:0] rdata_nxt =
    (i_reg_addr == VRTC_ADDR_LOAD_LINE) ? load_line_r :
    (i_reg_addr == VRTC_ADDR_TRANSIENT) ? transient_r :
    (i_reg_addr == VRTC_ADDR_MAX_CURR)  ? max_curr_r  :
    (i_reg_addr == VRTC_ADDR_BOOT_VOLT) ? boot_volt_r :
    (i_reg_addr == VRTC_ADDR_FREQ_SS)   ? freq_ss_r   : 8'h00;

  wire logic [2:0] under_c = transient_nxt[VRTC_UNDER_LSB +: 3];
  wire logic [2:0] over_c  = transient_nxt[VRTC_OVER_LSB +: 3];
  wire logic [1:0] rise_c  = freq_ss_nxt[VRTC_RISE_LSB +: 2];

  // Strap capture only once, after reset release, since reset flops take constants
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      strap_done_r <= 1'b0;
      load_line_r  <= VRTC_RST_LOAD_LINE;
      transient_r  <= VRTC_RST_TRANSIENT;
      max_curr_r   <= VRTC_RST_MAX_CURR;
      boot_volt_r  <= VRTC_RST_BOOT_VOLT;
      freq_ss_r    <= VRTC_RST_FREQ_SS;
    end
    else
    begin
      strap_done_r <= 1'b1;
      load_line_r  <= load_line_nxt;
      transient_r  <= transient_nxt;
      max_curr_r   <= max_curr_nxt;
      boot_volt_r  <= boot_volt_nxt;
      freq_ss_r    <= freq_ss_nxt;
    end
  end

  // Outputs registered; decode follows the next register value so they align with it
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_reg_rdata                <= 8'h00;
      o_reg_hit                  <= 1'b0;
      o_load_line_pct            <= 8'd100;
      o_undershoot_threshold     <= VRTC_THR_OFF;
      o_undershoot_enable        <= 1'b0;
      o_undershoot_mv            <= 8'h00;
      o_overshoot_threshold      <= VRTC_THR_OFF;
      o_overshoot_enable         <= 1'b0;
      o_overshoot_mv             <= 8'h00;
      o_max_current_value        <= VRTC_RST_MAX_CURR;
      o_boot_voltage_field       <= VRTC_RST_BOOT_VOLT;
      o_boot_vid_table           <= 1'b0;
      o_switching_frequency_code <= VRTC_RST_FREQ_SS[7:4];
      o_switching_frequency_khz  <= 10'd500;
      o_soft_start_rise_ratio    <= 2'h0;
      o_soft_start_divisor       <= 4'h1;
    end
    else
    begin
      o_reg_rdata                <= (i_reg_rd && addr_hit) ? rdata_nxt : 8'h00;
      o_reg_hit                  <= (i_reg_rd || i_reg_wr) && addr_hit;
      o_load_line_pct            <= ll_pct(load_line_nxt);
      o_undershoot_threshold     <= under_c;
      o_undershoot_enable        <= (under_c != VRTC_THR_OFF);
      o_undershoot_mv            <= thr_mv(under_c, 8'd20);
      o_overshoot_threshold      <= over_c;
      o_overshoot_enable         <= (over_c != VRTC_THR_OFF);
      o_overshoot_mv             <= thr_mv(over_c, 8'd30);
      o_max_current_value        <= max_curr_nxt;
      o_boot_voltage_field       <= boot_volt_nxt;
      o_boot_vid_table           <= i_vid_table_sel;
      o_switching_frequency_code <= freq_ss_nxt[VRTC_FSW_LSB +: 4];
      o_switching_frequency_khz  <= fsw_khz(freq_ss_nxt[VRTC_FSW_LSB +: 4]);
      o_soft_start_rise_ratio    <= rise_c;
      o_soft_start_divisor       <= 4'(4'h1 << rise_c);
    end
  end

  // Strap cycle, sampled reset keeps the release edge itself out
  sequence s_strap_cycle;
    i_reset_n && !strap_done_r;
  endsequence
  // Register write taken once the straps are in
  sequence s_write_after_strap(sel);
    strap_done_r && sel;
  endsequence

  a_reserved_zero: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (transient_r[7] == 1'b0) && (transient_r[3] == 1'b0)) else $error("reserved bits set");
  // write wins once straps are done
  a_thr_write_wins: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_write_after_strap(wr_tr) |=> transient_r == ($past(i_reg_wdata) & VRTC_MASK_TRANSIENT))
    else $error("threshold write lost");
  a_curr_write_wins: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_write_after_strap(wr_mc) |=> max_curr_r == $past(i_reg_wdata)) else $error("current write lost");
  a_boot_write_out: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_write_after_strap(wr_bv) |=> o_boot_voltage_field == $past(i_reg_wdata)) else $error("boot write lost");
  a_freq_write: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_write_after_strap(wr_fs) |=> freq_ss_r == ($past(i_reg_wdata) & VRTC_MASK_FREQ_SS))
    else $error("frequency write lost");
  a_vid_follow: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_reset_n |=> o_boot_vid_table == $past(i_vid_table_sel)) else $error("voltage table tag wrong");
  a_under_off: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    transient_r[6:4] == 3'h7 |-> !o_undershoot_enable && o_undershoot_mv == 8'h00) else $error("undershoot not off");
  a_over_off: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    transient_r[2:0] == 3'h7 |-> !o_overshoot_enable) else $error("overshoot not off");
  // unlisted code acts as full scale
  a_ll_other: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    load_line_r == 8'h05 |-> o_load_line_pct == 8'd100) else $error("load line default wrong");
  a_under_first: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    transient_r[6:4] == 3'h0 |-> o_undershoot_mv == 8'd20) else $error("undershoot 20 mV wrong");
  a_over_first: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    transient_r[2:0] == 3'h0 |-> o_overshoot_mv == 8'd30) else $error("overshoot 30 mV wrong");
  a_fsw_zero: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    freq_ss_r[7:4] == 4'h0 |-> o_switching_frequency_khz == 10'd300) else $error("frequency decode wrong");
  a_rise_eighth: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    freq_ss_r[1:0] == 2'h3 |-> o_soft_start_divisor == 4'h8) else $error("rise ratio wrong");
  a_nvm_default: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_strap_cycle ##0 (!i_transient_strap_valid && !i_reg_wr) |=> transient_r == VRTC_RST_TRANSIENT)
    else $error("default lost");
  a_thr_strap: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_strap_cycle ##0 i_transient_strap_valid |=>
      transient_r == ($past(i_transient_strap_pin) & VRTC_MASK_TRANSIENT))
    else $error("strap threshold lost");
  a_curr_strap: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_strap_cycle ##0 i_freq_current_strap_valid |=> max_curr_r == $past(i_freq_current_strap_pin))
    else $error("strap current lost");
  a_boot_strap: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_strap_cycle ##0 i_boot_strap_valid |=> boot_volt_r == $past(i_boot_strap_pin))
    else $error("strap boot code lost");
  a_freq_strap: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    s_strap_cycle ##0 i_freq_current_strap_valid |=>
      freq_ss_r == ($past(i_freq_current_strap_freq) & VRTC_MASK_FREQ_SS))
    else $error("strap frequency lost");
endmodule
`default_nettype wire

// >>> tb/tb_vrtc_regs.sv
// Self-checking bench for the tuning register bank
`timescale 1ns/1ps
`default_nettype none
module tb_vrtc_regs;
  import vrtc_pkg::*;
  logic       i_mclk = 1'b0, i_reset_n = 1'b0, i_vid_table_sel = 1'b0, i_reg_wr, i_reg_rd, o_reg_hit;
  logic       i_transient_strap_valid = 1'b0, i_freq_current_strap_valid = 1'b0, i_boot_strap_valid = 1'b0;
  logic [7:0] i_transient_strap_pin = 8'h00, i_freq_current_strap_pin = 8'h00;
  logic [7:0] i_freq_current_strap_freq = 8'h00, i_boot_strap_pin = 8'h00;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_load_line_pct, o_undershoot_mv, o_overshoot_mv;
  logic [7:0] o_max_current_value, o_boot_voltage_field;
  logic [2:0] o_undershoot_threshold, o_overshoot_threshold;
  logic       o_undershoot_enable, o_overshoot_enable, o_boot_vid_table;
  logic [3:0] o_switching_frequency_code, o_soft_start_divisor;
  logic [9:0] o_switching_frequency_khz;
  logic [1:0] o_soft_start_rise_ratio;
  logic [7:0] regs [5];
  int         num_errors = 0;
  int         checks_done = 0;
  localparam logic [7:0] UMV [8] = '{8'd20, 8'd30, 8'd60, 8'd80, 8'd100, 8'd120, 8'd140, 8'd0};
  localparam logic [7:0] OMV [8] = '{8'd30, 8'd40, 8'd60, 8'd80, 8'd100, 8'd120, 8'd140, 8'd0};
  localparam logic [9:0] KHZ [16] = '{10'd300, 10'd400, 10'd500, 10'd600, 10'd700, 10'd800, 10'd900, 10'd1000,
                                      10'd300, 10'd450, 10'd350, 10'd650, 10'd550, 10'd850, 10'd950, 10'd1000};
  localparam logic [7:0] LL [19] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50,
                                     8'h60, 8'h70, 8'h80, 8'h90, 8'hA0, 8'hB0, 8'hC0, 8'h05, 8'h11};

  always #12.5 i_mclk = ~i_mclk;

  vrtc_regs DUT (.i_mclk, .i_reset_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_reg_hit,
    .i_transient_strap_pin, .i_transient_strap_valid, .i_freq_current_strap_pin, .i_freq_current_strap_freq,
    .i_freq_current_strap_valid, .i_boot_strap_pin, .i_boot_strap_valid, .i_vid_table_sel, .o_load_line_pct,
    .o_undershoot_threshold, .o_undershoot_enable, .o_undershoot_mv, .o_overshoot_threshold, .o_overshoot_enable,
    .o_overshoot_mv, .o_max_current_value, .o_boot_voltage_field, .o_boot_vid_table, .o_switching_frequency_code,
    .o_switching_frequency_khz, .o_soft_start_rise_ratio, .o_soft_start_divisor);

  vrtc_host_model host (.i_mclk(i_mclk), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata), .o_wr(i_reg_wr),
    .o_rd(i_reg_rd), .i_rdata(o_reg_rdata), .i_hit(o_reg_hit));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [7:0] exp_pct(input logic [7:0] c);
    if (c <= 8'h04)
      return c * 8'd25;
    if (c[3:0] != 4'h0 || c[7:4] > 4'hB)
      return 8'd100;
    if (c[7:4] <= 4'h4)
      return 8'd75 + 8'(c[7:4]) * 8'd5;
    if (c[7:4] <= 4'h9)
      return 8'd80 + 8'(c[7:4]) * 8'd5;
    return (c[7:4] == 4'hA) ? 8'd150 : 8'd175;
  endfunction

  // Decoded outputs first, while the write's effect is fresh, then read back every register
  task automatic check_all();
    logic [7:0] rd;
    logic       hit;
    check("pct", o_load_line_pct, exp_pct(regs[0]));
    check("under code", o_undershoot_threshold, regs[1][6:4]);
    check("under mv", o_undershoot_mv, UMV[regs[1][6:4]]);
    check("under en", o_undershoot_enable, regs[1][6:4] != 3'h7);
    check("over code", o_overshoot_threshold, regs[1][2:0]);
    check("over mv", o_overshoot_mv, OMV[regs[1][2:0]]);
    check("over en", o_overshoot_enable, regs[1][2:0] != 3'h7);
    check("max_current_value", o_max_current_value, regs[2]);
    check("boot", o_boot_voltage_field, regs[3]);
    check("vid table", o_boot_vid_table, i_vid_table_sel);
    check("fsw code", o_switching_frequency_code, regs[4][7:4]);
    check("fsw khz", o_switching_frequency_khz, KHZ[regs[4][7:4]]);
    check("rise", o_soft_start_rise_ratio, regs[4][1:0]);
    check("divisor", o_soft_start_divisor, 16'd1 << regs[4][1:0]);
    for (int i = 0; i < 5; i++)
    begin
      host.access(1'b0, 8'hD8 + 8'(i), 8'h00, rd, hit);
      check("rdata", rd, regs[i]);
      check("rd hit", hit, 1'b1);
    end
    host.access(1'b0, 8'hDD, 8'h00, rd, hit);
    check("unmapped rd", {rd, 7'h00, hit}, 16'h0000);
  endtask

  task automatic put(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] rd;
    logic       hit;
    host.access(1'b1, a, d, rd, hit);
    check("wr hit", hit, a >= 8'hD8 && a <= 8'hDC);
    if (a == 8'hD9)
      regs[1] = d & 8'h77;
    else if (a == 8'hDC)
      regs[4] = d & 8'hF3;
    else if (a >= 8'hD8 && a <= 8'hDC)
      regs[a - 8'hD8] = d;
    check_all();
  endtask

  task automatic do_reset(input logic strap);
    @(posedge i_mclk);
    i_reset_n <= 1'b0;
    {i_transient_strap_pin, i_freq_current_strap_pin, i_freq_current_strap_freq} <= 24'($urandom);
    i_boot_strap_pin <= 8'($urandom);
    {i_transient_strap_valid, i_freq_current_strap_valid, i_boot_strap_valid} <= {3{strap}};
    repeat (6) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    @(posedge i_mclk);
    // Strap values land on this edge; look once they have settled
    #1;
    // Strap values win over the stored defaults when fitted
    regs = '{8'h04, strap ? i_transient_strap_pin & 8'h77 : 8'h77, strap ? i_freq_current_strap_pin : 8'h78,
             strap ? i_boot_strap_pin : 8'h97, strap ? i_freq_current_strap_freq & 8'hF3 : 8'h20};
    check_all();
  endtask

  initial
  begin
    repeat (100000) @(posedge i_mclk);
    num_errors++;
    print_verdict();
  end

  initial
  begin
    void'($urandom(80));
    do_reset(1'b0);
    for (int c = 0; c < 8; c++)
      put(8'hD9, {1'b1, 3'(c), 1'b1, 3'(7 - c)});
    for (int c = 0; c < 16; c++)
      put(8'hDC, {4'(c), 2'b11, 2'(c)});
    for (int c = 0; c < 19; c++)
      put(8'hD8, LL[c]);
    do_reset(1'b1);
    for (int n = 0; n < 60; n++)
    begin
      @(posedge i_mclk);
      i_vid_table_sel <= 1'($urandom);
      put(8'hD7 + 8'($urandom % 7), 8'($urandom));
    end
    print_verdict();
  end
endmodule
`default_nettype wire

// >>> tb/vrtc_host_model.sv
// Host model: single-byte register writes and reads on the device register port
`timescale 1ns/1ps
`default_nettype none
module vrtc_host_model
(
  // Clock
  input  wire logic       i_mclk,
  // Request towards the device
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd,
  // Answer from the device
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_hit
);
  initial
  begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // One-cycle strobe, answer sampled after the taking edge; bus scrambled once released
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data,
                        output logic [7:0] rdata, output logic hit);
    @(posedge i_mclk);
    o_addr  <= addr;
    o_wdata <= data;
    o_wr    <= wr;
    o_rd    <= ~wr;
    @(posedge i_mclk);
    o_wr    <= 1'b0;
    o_rd    <= 1'b0;
    o_addr  <= ~addr;
    o_wdata <= ~data;
    #1;
    rdata = i_rdata;
    hit   = i_hit;
  endtask
endmodule
`default_nettype wire
